/* File: pkg/ealu_pkg.sv */
// Constants, types and carriers shared by the eight-bit arithmetic datapath.
// Assumes a single core clock and a decoder that supplies operands each request.
//
// Notes on behaviour
// - Register add writes sum to destination; updates Z,C,N,V,H; one cycle.
// - Add with carry adds both registers plus carry; updates Z,C,N,V,H; one cycle.
// - Word add adds immediate to register pair; updates Z,C,N,V,S; two cycles.
// - Subtract register or immediate from destination; updates Z,C,N,V,H; one cycle.
// - Subtract operand and carry from destination; updates Z,C,N,V,H; one cycle.
// - Word subtract takes immediate from register pair; updates Z,C,N,V,S; two cycles.
// - AND, OR with register or constant, exclusive OR with register; update Z,N,V only; one cycle.
// - Mask-set ORs constant; mask-clear ANDs with all-ones minus constant; Z,N,V.
// - Test ANDs register with itself, value unchanged; sets Z,N,V; one cycle.
// - Three multiplies put 16-bit product in pair 1:0; update Z,C; two cycles.
// - Fractional multiplies shift product left one; pair 1:0; Z,C; two cycles.
package ealu_pkg;

    // ------------------------------------------------------------------
    // Status flag positions and masks
    // ------------------------------------------------------------------
    localparam int FLAG_C = 0;
    localparam int FLAG_Z = 1;
    localparam int FLAG_N = 2;
    localparam int FLAG_V = 3;
    localparam int FLAG_S = 4;
    localparam int FLAG_H = 5;

    localparam logic [7:0] MASK_NONE  = 8'h00;
    localparam logic [7:0] MASK_ZC    = 8'h03;
    localparam logic [7:0] MASK_ZNV   = 8'h0E;
    localparam logic [7:0] MASK_ZCNV  = 8'h0F;
    localparam logic [7:0] MASK_ZCNVS = 8'h1F;
    localparam logic [7:0] MASK_ZCNVH = 8'h2F;

    // ------------------------------------------------------------------
    // Data constants and cycle counts
    // ------------------------------------------------------------------
    localparam logic [7:0] ALL_ONES = 8'hFF;
    localparam logic [7:0] ZERO8    = 8'h00;
    localparam logic [7:0] MIN_NEG  = 8'h80;
    localparam logic [7:0] MAX_POS  = 8'h7F;
    localparam logic [1:0] CYCLES_SHORT = 2'h1;
    localparam logic [1:0] CYCLES_LONG  = 2'h2;
    localparam logic [1:0] CNT_RESET    = 2'h0;

    // ------------------------------------------------------------------
    // Operation codes selected by the decoder
    // ------------------------------------------------------------------
    typedef enum logic [4:0] {
        OP_ADD        = 5'h00, OP_ADD_CARRY  = 5'h01, OP_WORD_ADD   = 5'h02,
        OP_SUB        = 5'h03, OP_SUB_IMM    = 5'h04, OP_SUB_CARRY  = 5'h05,
        OP_SUB_IMM_C  = 5'h06, OP_WORD_SUB   = 5'h07, OP_AND        = 5'h08,
        OP_AND_IMM    = 5'h09, OP_OR         = 5'h0A, OP_OR_IMM     = 5'h0B,
        OP_XOR        = 5'h0C, OP_ONES_COMP  = 5'h0D, OP_TWOS_COMP  = 5'h0E,
        OP_MASK_SET   = 5'h0F, OP_MASK_CLEAR = 5'h10, OP_INC        = 5'h11,
        OP_DEC        = 5'h12, OP_TEST       = 5'h13, OP_CLEAR      = 5'h14,
        OP_SET_ONES   = 5'h15, OP_MUL_U      = 5'h16, OP_MUL_S      = 5'h17,
        OP_MUL_SU     = 5'h18, OP_FRACTIONAL_MULTIPLY_UNSIGNED_U     = 5'h19, OP_FRACTIONAL_MULTIPLY_UNSIGNED_S     = 5'h1A,
        OP_FRACTIONAL_MULTIPLY_UNSIGNED_SU    = 5'h1B
    } ealu_op_t;

    // ------------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        ealu_op_t   op;
        logic [7:0] a;      // Destination, or low byte of the pair.
        logic [7:0] b;      // Source register or immediate.
        logic [7:0] a_hi;   // High byte of the pair for word operations.
        logic [7:0] flags;  // Current status flags.
    } ealu_req_t;

    typedef struct packed {
        logic       done;
        logic       write_en;
        logic       wide;
        logic       pair_fixed;
        logic [7:0] res_lo;
        logic [7:0] res_hi;
        logic [7:0] flags;
        logic [7:0] flag_mask;
    } ealu_ans_t;

    typedef struct packed {
        logic [7:0] r;
        logic       h;
        logic       c;
        logic       v;
    } ealu_arith_t;

    localparam ealu_ans_t ANS_RESET = '0;

endpackage

/* File: rtl/ealu_datapath.sv */
// Eight-bit arithmetic and logic datapath with multiplier and word unit.
// Assumes the decoder and register file run on ref_clk and hold a request
// only for the cycle in which req_valid is high and busy is low.
`timescale 1ns/1ps
`default_nettype none

module ealu_datapath
    import ealu_pkg::*;
(
    // Clock, reset and enable
    input  wire logic      ref_clk,
    input  wire logic      reset_n,
    input  wire logic      clk_en,
    // Request from the decoder
    input  wire logic      req_valid,
    input  wire ealu_req_t req,
    // Answer to the register file
    output var  ealu_ans_t ans,
    output logic           busy
);

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------

    // Eight-bit add with carry in, giving half carry, carry and overflow.
    function automatic ealu_arith_t add8(input logic [7:0] a, input logic [7:0] b,
                                         input logic cin);
        ealu_arith_t o;
        o.r = a + b + {7'h00, cin};
        o.h = (a[3] & b[3]) | (b[3] & ~o.r[3]) | (~o.r[3] & a[3]);
        o.c = (a[7] & b[7]) | (b[7] & ~o.r[7]) | (~o.r[7] & a[7]);
        o.v = (a[7] & b[7] & ~o.r[7]) | (~a[7] & ~b[7] & o.r[7]);
        return o;
    endfunction

    // Eight-bit subtract with borrow in; carry reads as borrow out.
    function automatic ealu_arith_t sub8(input logic [7:0] a, input logic [7:0] b,
                                         input logic cin);
        ealu_arith_t o;
        o.r = a - b - {7'h00, cin};
        o.h = (~a[3] & b[3]) | (b[3] & o.r[3]) | (o.r[3] & ~a[3]);
        o.c = (~a[7] & b[7]) | (b[7] & o.r[7]) | (o.r[7] & ~a[7]);
        o.v = (a[7] & ~b[7] & ~o.r[7]) | (~a[7] & b[7] & o.r[7]);
        return o;
    endfunction

    // Flags of a logic result: overflow cleared, zero and sign from the byte.
    function automatic logic [7:0] logic_flags(input logic [7:0] r);
        logic [7:0] f;
        f         = 8'h00;
        f[FLAG_Z] = (r == ZERO8);
        f[FLAG_N] = r[7];
        return f;
    endfunction

    // Flags of an eight-bit arithmetic result; chained ops keep a prior zero.
    function automatic logic [7:0] arith_flags(input ealu_arith_t x, input logic chain,
                                               input logic zin);
        logic [7:0] f;
        f         = 8'h00;
        f[FLAG_C] = x.c;
        f[FLAG_Z] = (x.r == ZERO8) & (~chain | zin);
        f[FLAG_N] = x.r[7];
        f[FLAG_V] = x.v;
        f[FLAG_H] = x.h;
        return f;
    endfunction

    // ------------------------------------------------------------------
    // Combinational operation unit
    // ------------------------------------------------------------------
    ealu_ans_t   calc;
    logic [1:0]  calc_cycles;
    ealu_arith_t ar;
    logic [16:0] word_sum;
    logic [15:0] word_val;
    logic [15:0] prod;
    logic [15:0] mres;
    logic        cin;

    always_comb begin
        cin         = req.flags[FLAG_C];
        ar          = add8(req.a, req.b, 1'b0);
        word_val    = {req.a_hi, req.a};
        word_sum    = 17'h00000;
        prod        = 16'h0000;
        mres        = 16'h0000;
        calc        = ANS_RESET;
        calc_cycles = CYCLES_SHORT;
        calc.done     = 1'b1;
        calc.write_en = 1'b1;
        unique case (req.op)
            OP_ADD, OP_ADD_CARRY: begin
                ar = add8(req.a, req.b, (req.op == OP_ADD_CARRY) & cin);
                calc.res_lo    = ar.r;
                calc.flags     = arith_flags(ar, 1'b0, 1'b0);
                calc.flag_mask = MASK_ZCNVH;
            end
            OP_SUB, OP_SUB_IMM, OP_SUB_CARRY, OP_SUB_IMM_C: begin
                // Carry variants only keep zero set if it was already set,
                // so that multi-byte differences test zero over all bytes.
                if (req.op == OP_SUB_CARRY || req.op == OP_SUB_IMM_C) begin
                    ar = sub8(req.a, req.b, cin);
                    calc.flags = arith_flags(ar, 1'b1, req.flags[FLAG_Z]);
                end else begin
                    ar = sub8(req.a, req.b, 1'b0);
                    calc.flags = arith_flags(ar, 1'b0, 1'b0);
                end
                calc.res_lo    = ar.r;
                calc.flag_mask = MASK_ZCNVH;
            end
            OP_WORD_ADD, OP_WORD_SUB: begin
                if (req.op == OP_WORD_ADD) begin
                    word_sum = {1'b0, word_val} + {9'h000, req.b};
                    calc.flags[FLAG_V] = ~req.a_hi[7] & word_sum[15];
                    calc.flags[FLAG_C] = req.a_hi[7] & ~word_sum[15];
                end else begin
                    word_sum = {1'b0, word_val} - {9'h000, req.b};
                    calc.flags[FLAG_V] = req.a_hi[7] & ~word_sum[15];
                    calc.flags[FLAG_C] = ~req.a_hi[7] & word_sum[15];
                end
                calc.res_lo        = word_sum[7:0];
                calc.res_hi        = word_sum[15:8];
                calc.wide          = 1'b1;
                calc.flags[FLAG_Z] = (word_sum[15:0] == 16'h0000);
                calc.flags[FLAG_N] = word_sum[15];
                calc.flags[FLAG_S] = word_sum[15] ^ calc.flags[FLAG_V];
                calc.flag_mask     = MASK_ZCNVS;
                calc_cycles        = CYCLES_LONG;
            end
            OP_AND, OP_AND_IMM, OP_OR, OP_OR_IMM, OP_XOR,
            OP_MASK_SET, OP_MASK_CLEAR, OP_TEST, OP_CLEAR: begin
                unique case (req.op)
                    OP_AND, OP_AND_IMM: calc.res_lo = req.a & req.b;
                    OP_OR, OP_OR_IMM:   calc.res_lo = req.a | req.b;
                    OP_XOR:             calc.res_lo = req.a ^ req.b;
                    OP_MASK_SET:        calc.res_lo = req.a | req.b;
                    OP_MASK_CLEAR:      calc.res_lo = req.a & (ALL_ONES - req.b);
                    OP_TEST:            calc.res_lo = req.a & req.a;
                    default:            calc.res_lo = req.a ^ req.a;
                endcase
                // Test leaves the register alone, so nothing is written back.
                calc.write_en  = (req.op != OP_TEST);
                calc.flags     = logic_flags(calc.res_lo);
                calc.flag_mask = MASK_ZNV;
            end
            OP_ONES_COMP: begin
                calc.res_lo        = ALL_ONES - req.a;
                calc.flags         = logic_flags(calc.res_lo);
                calc.flags[FLAG_C] = 1'b1;
                calc.flag_mask     = MASK_ZCNV;
            end
            OP_TWOS_COMP: begin
                ar = sub8(ZERO8, req.a, 1'b0);
                calc.res_lo    = ar.r;
                calc.flags     = arith_flags(ar, 1'b0, 1'b0);
                calc.flag_mask = MASK_ZCNVH;
            end
            OP_INC, OP_DEC: begin
                calc.res_lo = (req.op == OP_INC) ? req.a + 8'h01 : req.a - 8'h01;
                calc.flags  = logic_flags(calc.res_lo);
                calc.flags[FLAG_V] = (req.op == OP_INC) ? (calc.res_lo == MIN_NEG)
                                                        : (calc.res_lo == MAX_POS);
                calc.flag_mask = MASK_ZNV;
            end
            OP_SET_ONES: begin
                calc.res_lo    = ALL_ONES;
                calc.flag_mask = MASK_NONE;
            end
            OP_MUL_U, OP_MUL_S, OP_MUL_SU, OP_FRACTIONAL_MULTIPLY_UNSIGNED_U, OP_FRACTIONAL_MULTIPLY_UNSIGNED_S, OP_FRACTIONAL_MULTIPLY_UNSIGNED_SU: begin
                unique case (req.op)
                    // Extended to 16 bits first, so the whole 16-bit product is exact for every sign mode.
                    OP_MUL_U, OP_FRACTIONAL_MULTIPLY_UNSIGNED_U: prod = {8'h00, req.a} * {8'h00, req.b};
                    OP_MUL_S, OP_FRACTIONAL_MULTIPLY_UNSIGNED_S: prod = {{8{req.a[7]}}, req.a} * {{8{req.b[7]}}, req.b};
                    default:             prod = {{8{req.a[7]}}, req.a} * {8'h00, req.b};
                endcase
                // Fractional forms shift after the carry is taken from bit 15.
                if (req.op == OP_FRACTIONAL_MULTIPLY_UNSIGNED_U || req.op == OP_FRACTIONAL_MULTIPLY_UNSIGNED_S || req.op == OP_FRACTIONAL_MULTIPLY_UNSIGNED_SU) begin
                    mres = {prod[14:0], 1'b0};
                end else begin
                    mres = prod;
                end
                calc.res_lo        = mres[7:0];
                calc.res_hi        = mres[15:8];
                calc.wide          = 1'b1;
                calc.pair_fixed    = 1'b1;
                calc.flags[FLAG_C] = prod[15];
                calc.flags[FLAG_Z] = (mres == 16'h0000);
                calc.flag_mask     = MASK_ZC;
                calc_cycles        = CYCLES_LONG;
            end
            default: begin
                // Unused codes answer with no write and no flag change.
                calc.write_en  = 1'b0;
                calc.flag_mask = MASK_NONE;
            end
        endcase
        // Flags outside the mask carry the current value through.
        calc.flags = (calc.flags & calc.flag_mask) | (req.flags & ~calc.flag_mask);
    end

    // ------------------------------------------------------------------
    // Issue and completion sequencing
    // ------------------------------------------------------------------
    ealu_ans_t  ans_ff,  nxt_ans;
    ealu_ans_t  pend_ff, nxt_pend;
    logic [1:0] cnt_ff,  nxt_cnt;
    logic       busy_ff, nxt_busy;

    // A long operation parks its answer and releases it after the last cycle;
    // requests arriving meanwhile are dropped, so the decoder must stall on busy.
    always_comb begin
        nxt_ans  = ans_ff;
        nxt_pend = pend_ff;
        nxt_cnt  = cnt_ff;
        nxt_busy = busy_ff;
        nxt_ans.done     = 1'b0;
        nxt_ans.write_en = 1'b0;
        if (cnt_ff != CNT_RESET) begin
            nxt_cnt = cnt_ff - 2'h1;
            if (cnt_ff == CYCLES_SHORT) begin
                nxt_ans  = pend_ff;
                nxt_busy = 1'b0;
            end
        end else if (req_valid) begin
            if (calc_cycles == CYCLES_SHORT) begin
                nxt_ans = calc;
            end else begin
                nxt_pend = calc;
                nxt_cnt  = calc_cycles - 2'h1;
                nxt_busy = 1'b1;
            end
        end
    end

    // State registers, frozen while the clock enable is low.
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            ans_ff  <= ANS_RESET;
            pend_ff <= ANS_RESET;
            cnt_ff  <= CNT_RESET;
            busy_ff <= 1'b0;
        end else if (clk_en) begin
            ans_ff  <= nxt_ans;
            pend_ff <= nxt_pend;
            cnt_ff  <= nxt_cnt;
            busy_ff <= nxt_busy;
        end
    end

    assign ans  = ans_ff;
    assign busy = busy_ff;

endmodule

`default_nettype wire

/* File: tb/ealu_checker.sv */
// Concurrent checks on the request and answer ports of the datapath.
// Assumes it is bound to ealu_datapath and sees nothing but its ports.
`timescale 1ns/1ps
`default_nettype none

module ealu_checker
    import ealu_pkg::*;
(
    // Clock and reset
    input wire logic      ref_clk,
    input wire logic      reset_n,
    // Request side
    input wire logic      clk_en,
    input wire logic      req_valid,
    input wire ealu_req_t req,
    // Answer side
    input wire ealu_ans_t ans,
    input wire logic      busy
);
    logic        taken;
    logic        long_op;
    logic        logic_op;
    logic        mul_op;
    logic [7:0]  sum8;
    logic [15:0] fractional_multiply_unsigned_u;

    // Busy is still high on the edge where a long op ends, so taken sees every request the datapath accepts.
    assign taken    = clk_en && req_valid && !busy;
    assign mul_op   = req.op inside {[OP_MUL_U:OP_FRACTIONAL_MULTIPLY_UNSIGNED_SU]};
    assign long_op  = mul_op || req.op inside {OP_WORD_ADD, OP_WORD_SUB};
    assign logic_op = req.op inside {[OP_AND:OP_XOR], OP_MASK_SET, OP_MASK_CLEAR};
    assign sum8     = req.a + req.b;
    assign fractional_multiply_unsigned_u   = ({8'h00, req.a} * {8'h00, req.b}) << 1;

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!reset_n);

    property p_short_answer;
        taken && !long_op |=> ans.done && !busy;
    endproperty
    a_short_answer: assert property (p_short_answer)
        else $error("one-cycle op gave no answer");
    property p_long_busy;
        taken && long_op |=> busy && !ans.done;
    endproperty
    a_long_busy: assert property (p_long_busy)
        else $error("two-cycle op answered early");
    property p_long_answer;
        taken && long_op ##1 clk_en |=> ans.done && !busy;
    endproperty
    a_long_answer: assert property (p_long_answer)
        else $error("two-cycle op answer missing");
    property p_add_sum;
        taken && req.op == OP_ADD |=> ans.res_lo == $past(sum8);
    endproperty
    a_add_sum: assert property (p_add_sum)
        else $error("add result wrong");
    property p_keep_flags;
        taken && !long_op |=> ((ans.flags ^ $past(req.flags)) & ~ans.flag_mask) == 8'h00;
    endproperty
    a_keep_flags: assert property (p_keep_flags)
        else $error("unmasked flag changed");
    property p_logic_mask;
        taken && logic_op |=> ans.flag_mask == MASK_ZNV && ans.write_en;
    endproperty
    a_logic_mask: assert property (p_logic_mask)
        else $error("logic op flag mask wrong");
    property p_mul_pair;
        taken && mul_op ##1 clk_en |=> ans.pair_fixed && ans.wide && ans.flag_mask == MASK_ZC;
    endproperty
    a_mul_pair: assert property (p_mul_pair)
        else $error("multiply destination or mask wrong");
    property p_frac;
        taken && req.op == OP_FRACTIONAL_MULTIPLY_UNSIGNED_U ##1 clk_en |=> {ans.res_hi, ans.res_lo} == $past(fractional_multiply_unsigned_u, 2);
    endproperty
    a_frac: assert property (p_frac)
        else $error("fractional product wrong");
    property p_set_ones;
        taken && req.op == OP_SET_ONES |=> ans.res_lo == ALL_ONES && ans.flag_mask == MASK_NONE;
    endproperty
    a_set_ones: assert property (p_set_ones)
        else $error("set-all-ones wrong");
    property p_test;
        taken && req.op == OP_TEST |=> !ans.write_en && ans.flag_mask == MASK_ZNV;
    endproperty
    a_test: assert property (p_test)
        else $error("test op wrote back");
endmodule

bind ealu_datapath ealu_checker u_chk (
    .ref_clk   (ref_clk),
    .reset_n   (reset_n),
    .clk_en    (clk_en),
    .req_valid (req_valid),
    .req       (req),
    .ans       (ans),
    .busy      (busy)
);

`default_nettype wire

/* File: tb/ealu_decoder_model.sv */
// Decoder and register-file stand-in that presents requests to the datapath.
// Assumes the bench raises issue just after an edge, for the cycles it wants.
`timescale 1ns/1ps
`default_nettype none

module ealu_decoder_model
    import ealu_pkg::*;
(
    // Clock and reset
    input wire logic       ref_clk,
    input wire logic       reset_n,
    // Command from the bench
    input wire logic       issue,
    input wire ealu_req_t  cmd,
    // Datapath side
    input wire ealu_ans_t  ans,
    output logic           req_valid,
    output ealu_req_t      req,
    output logic [7:0]     wr_count
);
    ealu_req_t last_ff;

    // Remember the last request and count write-backs into the register file.
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            last_ff  <= '0;
            wr_count <= 8'h00;
        end else begin
            if (issue)
                last_ff <= cmd;
            if (ans.done && ans.write_en)
                wr_count <= wr_count + 8'h01;
        end
    end

    // Idle operand lines show the inverse of the last request, never stale data.
    assign req_valid = issue;
    assign req       = issue ? cmd : ealu_req_t'(~last_ff);
endmodule

`default_nettype wire

/* File: tb/tb.sv */
// Self-checking bench for the datapath, one task per scenario.
// Assumes the package and the decoder model are compiled first.
`timescale 1ns/1ps
`default_nettype none

module tb
    import ealu_pkg::*;
;
    logic       ref_clk  = 1'b0;
    logic       reset_n  = 1'b0;
    logic       clk_en   = 1'b1;
    logic       issue    = 1'b0;
    logic       stall_nx = 1'b0;
    ealu_req_t  cmd      = '0;
    logic       req_valid;
    ealu_req_t  req;
    ealu_ans_t  ans;
    logic       busy;
    logic [7:0] wr_count;
    int         fail_count  = 0;
    int         checks_done = 0;

    // Free-running core clock.
    always #50 ref_clk = ~ref_clk;

    ealu_datapath u_dut (.ref_clk(ref_clk), .reset_n(reset_n), .clk_en(clk_en),
        .req_valid(req_valid), .req(req), .ans(ans), .busy(busy));
    ealu_decoder_model u_dec (.ref_clk(ref_clk), .reset_n(reset_n), .issue(issue),
        .cmd(cmd), .ans(ans), .req_valid(req_valid), .req(req), .wr_count(wr_count));

    // ------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------
    task automatic finish_test;
        $display("fail_count=%0d checks_done=%0d", fail_count, checks_done);
        if (fail_count == 0 && checks_done > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            fail_count++;
            $display("FAIL %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // One request, then latency, result, write-back and flags are judged.
    task automatic run(input ealu_op_t op, input logic [15:0] a, input logic [7:0] b, fl,
                       input logic [15:0] res, input logic [7:0] mask, fx);
        int   n;
        logic lng;
        logic we;
        logic st;
        logic [7:0] wc;
        lng = op inside {[OP_MUL_U:OP_FRACTIONAL_MULTIPLY_UNSIGNED_SU], OP_WORD_ADD, OP_WORD_SUB};
        wc  = wr_count;
        we  = op != OP_TEST && op <= OP_FRACTIONAL_MULTIPLY_UNSIGNED_SU;
        st  = stall_nx;
        @(posedge ref_clk);
        #1;
        issue = 1'b1;
        cmd   = '{op, a[7:0], b, a[15:8], fl};
        @(posedge ref_clk);
        #1;
        issue = 1'b0;
        n     = 1;
        // A held-off clock enable must stretch the count, not lose the answer.
        if (st) begin
            clk_en = 1'b0;
            repeat (2) @(posedge ref_clk);
            #1;
            clk_en   = 1'b1;
            stall_nx = 1'b0;
            n        = 3;
        end
        while (ans.done !== 1'b1 && n < 8) begin
            @(posedge ref_clk);
            #1;
            n++;
        end
        chk(16'(n), 16'((lng ? 2 : 1) + (st ? 2 : 0)));
        chk(ans.write_en, we);
        chk(ans.flag_mask, mask);
        chk(ans.flags, (fl & ~mask) | fx);
        if (lng)
            chk({ans.res_hi, ans.res_lo}, res);
        else if (we)
            chk(ans.res_lo, res[7:0]);
        if (we)
            chk({ans.wide, ans.pair_fixed}, {lng, op >= OP_MUL_U});
        // The register file counts a write-back on the edge after done shows.
        @(posedge ref_clk);
        #1;
        chk(wr_count, wc + {7'h00, we});
    endtask

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_arith;
        run(OP_ADD, 16'h000F, 8'h01, 8'h00, 16'h0010, MASK_ZCNVH, 8'h20);
        run(OP_ADD, 16'h0080, 8'h80, 8'h10, 16'h0000, MASK_ZCNVH, 8'h0B);
        run(OP_ADD_CARRY, 16'h00FF, 8'h00, 8'h01, 16'h0000, MASK_ZCNVH, 8'h23);
        run(OP_SUB, 16'h0010, 8'h01, 8'h00, 16'h000F, MASK_ZCNVH, 8'h20);
        run(OP_SUB_IMM, 16'h0080, 8'h01, 8'h00, 16'h007F, MASK_ZCNVH, 8'h28);
        run(OP_SUB_CARRY, 16'h0000, 8'h00, 8'h01, 16'h00FF, MASK_ZCNVH, 8'h25);
        run(OP_SUB_IMM_C, 16'h0005, 8'h05, 8'h02, 16'h0000, MASK_ZCNVH, 8'h02);
        run(OP_WORD_ADD, 16'hFFFF, 8'h01, 8'h20, 16'h0000, MASK_ZCNVS, 8'h03);
        stall_nx = 1'b1;
        run(OP_WORD_SUB, 16'h0000, 8'h01, 8'h00, 16'hFFFF, MASK_ZCNVS, 8'h15);
    endtask

    // Stale V must be cleared and the untouched C and H must survive every logic op.
    task automatic t_logic;
        ealu_op_t   ops[7] = '{OP_AND, OP_AND_IMM, OP_OR, OP_OR_IMM, OP_XOR,
                               OP_MASK_SET, OP_MASK_CLEAR};
        logic [7:0] rs[7]  = '{8'h30, 8'h30, 8'hFC, 8'hFC, 8'hCC, 8'hFC, 8'hC0};
        foreach (ops[i])
            run(ops[i], 16'h00F0, 8'h3C, 8'h29, rs[i], MASK_ZNV, {5'h00, rs[i][7], 2'h0});
        run(OP_TEST, 16'h0000, 8'h00, 8'h08, 16'h0000, MASK_ZNV, 8'h02);
    endtask

    // Operands at the sign boundary separate the three signedness modes.
    task automatic t_mul;
        ealu_op_t    ops[6] = '{OP_MUL_U, OP_MUL_S, OP_MUL_SU, OP_FRACTIONAL_MULTIPLY_UNSIGNED_U, OP_FRACTIONAL_MULTIPLY_UNSIGNED_S, OP_FRACTIONAL_MULTIPLY_UNSIGNED_SU};
        logic [15:0] rs[6]  = '{16'h7F80, 16'h0080, 16'h8080, 16'hFF00, 16'h0100, 16'h0100};
        foreach (ops[i])
            run(ops[i], 16'h0080, 8'hFF, 8'h00, rs[i], MASK_ZC, {7'h00, i % 3 == 2});
    endtask

    task automatic t_misc;
        run(OP_ONES_COMP, 16'h0055, 8'h00, 8'h00, 16'h00AA, MASK_ZCNV, 8'h05);
        run(OP_TWOS_COMP, 16'h0001, 8'h00, 8'h00, 16'h00FF, MASK_ZCNVH, 8'h25);
        run(OP_INC, 16'h007F, 8'h00, 8'h00, 16'h0080, MASK_ZNV, 8'h0C);
        run(OP_DEC, 16'h0080, 8'h00, 8'h00, 16'h007F, MASK_ZNV, 8'h08);
        run(OP_CLEAR, 16'h005A, 8'h00, 8'h00, 16'h0000, MASK_ZNV, 8'h02);
        run(OP_SET_ONES, 16'h0012, 8'h00, 8'h2F, 16'h00FF, MASK_NONE, 8'h00);
        run(ealu_op_t'(5'h1C), 16'h0012, 8'h00, 8'h15, 16'h0000, MASK_NONE, 8'h00);
    endtask

    // Back-to-back short ops, then a short op held through the multiply's end.
    task automatic t_b2b;
        @(posedge ref_clk);
        #1;
        issue = 1'b1;
        cmd   = '{OP_ADD, 8'h01, 8'h02, 8'h00, 8'h00};
        @(posedge ref_clk);
        #1;
        chk(ans.res_lo, 8'h03);
        cmd = '{OP_SUB, 8'h09, 8'h04, 8'h00, 8'h00};
        @(posedge ref_clk);
        #1;
        chk({ans.done, ans.res_lo}, 9'h105);
        cmd = '{OP_MUL_U, 8'h02, 8'h03, 8'h00, 8'h00};
        @(posedge ref_clk);
        #1;
        chk({busy, ans.done}, 2'h2);
        cmd = '{OP_ADD, 8'h10, 8'h20, 8'h00, 8'h00};
        // The edge on which the product lands still refuses the add.
        @(posedge ref_clk);
        #1;
        chk({busy, ans.done}, 2'h1);
        chk({ans.res_hi, ans.res_lo}, 16'h0006);
        @(posedge ref_clk);
        #1;
        issue = 1'b0;
        chk({ans.done, ans.res_lo}, 9'h130);
    endtask

    // Reset in mid word op must clear the answer and busy at once.
    task automatic t_reset;
        @(posedge ref_clk);
        #1;
        issue = 1'b1;
        cmd   = '{OP_WORD_ADD, 8'h01, 8'h01, 8'h00, 8'h00};
        @(posedge ref_clk);
        #1;
        issue   = 1'b0;
        reset_n = 1'b0;
        #1;
        chk({busy, ans.done, ans.flag_mask}, 10'h000);
        @(posedge ref_clk);
        #1;
        reset_n = 1'b1;
        run(OP_INC, 16'h00FF, 8'h00, 8'h00, 16'h0000, MASK_ZNV, 8'h02);
    endtask

    // Main sequence.
    initial begin
        repeat (3) @(posedge ref_clk);
        #1;
        reset_n = 1'b1;
        t_arith;
        t_logic;
        t_mul;
        t_misc;
        t_b2b;
        t_reset;
        finish_test;
    end

    // Watchdog sized well beyond the roughly 115 cycles the run needs.
    initial begin
        #(3000 * 100);
        fail_count++;
        finish_test;
    end
endmodule

`default_nettype wire
